// file: logic/dwr_pkg.sv
// constants, command codes and state encoding of the dual wiper register block
// assumes a two-wire serial bus master and a free-running reference clock
//
// Functional notes
// - each channel holds a 6-bit wiper code that alone picks its tap
// - each channel has four 6-bit stored settings beside its wiper code
// - after reset, stored setting zero is copied into each wiper code
// - master writes wiper and stored settings only over the serial bus
// - 64 taps over 63 elements; every 6-bit code names one tap
// - four address pins set the bus address, first pin least significant
// - the device answers only when the sent address matches its pins
// - data line is open drain: pulled low or released, never driven high
// - all transfers in both directions are clocked by the master's serial clock
// - two channels, each with its own wiper code and stored settings
// - exactly one tap per channel connects to the wiper at any time
// - wiper codes and stored settings can be read and written over the bus
// - instructions copy between a wiper code and that channel's stored settings
// - an increment/decrement mode steps the wiper code instead of loading it
package dwr_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int CODE_W = 6;
  localparam int NUM_CH = 2;
  localparam int NUM_STORED = 4;
  localparam int TAP_NUM = 64;
  localparam logic [5:0] CODE_MAX = 6'h3F;
  localparam logic [5:0] STORED_RESET = 6'h00;
  localparam logic [63:0] TAP_ONE = 64'h0000_0000_0000_0001;
  ////////////////////////////////////////////////////////////////////////////////
  // address byte: [7:5] device type, [4:1] pins, [0] read
  localparam logic [2:0] DEV_TYPE = 3'h2; // arbitrary value
  localparam int ADDR_TYPE_LSB = 5;
  localparam int ADDR_PIN_LSB = 1;
  // instruction byte: [7:4] opcode, [2] channel, [1:0] stored index
  localparam int INS_OP_LSB = 4;
  localparam int INS_CH_BIT = 2;
  localparam int INS_IDX_LSB = 0;
  localparam int INC_BIT = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_STORED = 4'hB;
  localparam logic [3:0] OP_WR_STORED = 4'hC;
  localparam logic [3:0] OP_RECALL = 4'hD;
  localparam logic [3:0] OP_SAVE = 4'hE;
  localparam logic [3:0] OP_INCDEC = 4'h2;
  ////////////////////////////////////////////////////////////////////////////////
  // serial engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_INSTR = 4'h3,
    ST_INSTR_ACK = 4'h4,
    ST_DATA = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_READ = 4'h7,
    ST_READ_ACK = 4'h8
  } dwr_state_t;
endpackage

// file: logic/dwr_sync.sv
// two flip-flop synchroniser for levels and toggles
// assumes the destination clock runs while the value must pass
module dwr_sync #(
  parameter int WIDTH = 1
) (
  // clock and synchronous reset of the destination
  input wire logic clk,
  input wire logic rstn,
  // level from the other domain
  input wire logic [WIDTH-1:0] d,
  // synchronised level
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: logic/dwr_wiper_regs.sv
// dual wiper register block with two-wire serial slave
// assumes scl from the bus master, sda resolved outside from sdaOe
module dwr_wiper_regs (
  // system
  input wire logic ref_clk,
  input wire logic rstn,
  // serial bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // address straps
  input wire logic addrPinBit0,
  input wire logic addrPinBit1,
  input wire logic addrPinBit2,
  input wire logic addrPinBit3,
  // one-hot tap selects, bit 0 at the low end terminal
  output logic [dwr_pkg::TAP_NUM-1:0] wiperOutCh0,
  output logic [dwr_pkg::TAP_NUM-1:0] wiperOutCh1
);
  import dwr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // serial clock domain
  logic sclRstn;
  logic [3:0] addrPins;
  logic ackSync;
  dwr_state_t state_r;
  logic [2:0] bitCnt_r;
  logic [6:0] rxShift_r;
  logic [7:0] rxByte;
  logic [7:0] instr_r;
  logic [7:0] txShift_r;
  logic rw_r;
  logic sdaPos_r;
  logic startFlag_r;
  logic sdaOe_r;
  logic addrHit;
  logic insValid;
  logic byteDone;
  logic issueInstr;
  logic issueData;
  logic cmdTgl_r;
  logic [3:0] cmdOp_r;
  logic cmdCh_r;
  logic [1:0] cmdIdx_r;
  logic [5:0] cmdData_r;
  logic ackSeen_r;
  logic [5:0] rdHold_r;
  // reference clock domain
  logic cmdSync;
  logic cmdSeen_r;
  logic cmdEdge;
  logic recallPend_r;
  logic [5:0] wiperSetting_r [NUM_CH];
  logic [5:0] wiperSetting_nxt [NUM_CH];
  logic [5:0] storedWiperSetting_r [NUM_CH][NUM_STORED];
  logic [5:0] readback_r;
  logic rdTgl_r;

  // reset and straps brought onto the serial clock
  dwr_sync #(.WIDTH(1)) uRstSync (
    .clk(scl),
    .rstn(1'b1),
    .d(rstn),
    .q(sclRstn)
  );
  dwr_sync #(.WIDTH(4)) uAddrSync (
    .clk(scl),
    .rstn(sclRstn),
    .d({addrPinBit3, addrPinBit2, addrPinBit1, addrPinBit0}),
    .q(addrPins)
  );
  dwr_sync #(.WIDTH(1)) uAckSync (
    .clk(scl),
    .rstn(sclRstn),
    .d(rdTgl_r),
    .q(ackSync)
  );

  // byte decode
  assign rxByte = {rxShift_r, sdaIn};
  assign byteDone = (bitCnt_r == 3'h7);
  assign addrHit = (rxByte[7:ADDR_TYPE_LSB] == DEV_TYPE)
                   && (rxByte[ADDR_TYPE_LSB-1:ADDR_PIN_LSB] == addrPins);
  assign insValid = (rxByte[7:INS_OP_LSB] == OP_RD_WIPER) || (rxByte[7:INS_OP_LSB] == OP_WR_WIPER)
                    || (rxByte[7:INS_OP_LSB] == OP_RD_STORED)
                    || (rxByte[7:INS_OP_LSB] == OP_WR_STORED)
                    || (rxByte[7:INS_OP_LSB] == OP_RECALL) || (rxByte[7:INS_OP_LSB] == OP_SAVE)
                    || (rxByte[7:INS_OP_LSB] == OP_INCDEC);
  assign issueInstr = (state_r == ST_INSTR) && byteDone && insValid && !startFlag_r
                      && (rxByte[7:INS_OP_LSB] != OP_WR_WIPER)
                      && (rxByte[7:INS_OP_LSB] != OP_WR_STORED)
                      && (rxByte[7:INS_OP_LSB] != OP_INCDEC);
  assign issueData = (state_r == ST_DATA) && byteDone && !startFlag_r
                     && ((instr_r[7:INS_OP_LSB] == OP_WR_WIPER)
                     || (instr_r[7:INS_OP_LSB] == OP_WR_STORED)
                     || (instr_r[7:INS_OP_LSB] == OP_INCDEC));

  // data level at the rising edge, kept for start detection
  always_ff @(posedge scl)
  begin
    if (!sclRstn)
      sdaPos_r <= 1'b0;
    else
      sdaPos_r <= sdaIn;
  end

  // start seen: sda fell while scl was high
  always_ff @(negedge scl)
  begin
    if (!sclRstn)
      startFlag_r <= 1'b0;
    else
      startFlag_r <= sdaPos_r & ~sdaIn;
  end

  // bit engine, every transfer clocked by scl
  always_ff @(posedge scl)
  begin
    if (!sclRstn)
    begin
      state_r <= ST_IDLE;
      bitCnt_r <= 3'h0;
      rxShift_r <= 7'h00;
      instr_r <= 8'h00;
      txShift_r <= 8'h00;
      rw_r <= 1'b0;
    end
    else if (startFlag_r)
    begin
      state_r <= ST_ADDR;
      bitCnt_r <= 3'h1;
      rxShift_r <= {6'h00, sdaIn};
    end
    else
    begin
      rxShift_r <= rxByte[6:0];
      unique case (state_r)
        ST_IDLE: ;
        ST_ADDR:
        begin
          bitCnt_r <= bitCnt_r + 3'h1;
          if (byteDone)
          begin
            rw_r <= rxByte[0];
            state_r <= addrHit ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          bitCnt_r <= 3'h0;
          txShift_r <= {2'b00, rdHold_r};
          state_r <= rw_r ? ST_READ : ST_INSTR;
        end
        ST_INSTR:
        begin
          bitCnt_r <= bitCnt_r + 3'h1;
          if (byteDone)
          begin
            instr_r <= rxByte;
            state_r <= insValid ? ST_INSTR_ACK : ST_IDLE;
          end
        end
        ST_INSTR_ACK:
        begin
          bitCnt_r <= 3'h0;
          state_r <= ST_DATA;
        end
        ST_DATA:
        begin
          bitCnt_r <= bitCnt_r + 3'h1;
          if (byteDone)
            state_r <= ST_DATA_ACK;
        end
        ST_DATA_ACK:
        begin
          bitCnt_r <= 3'h0;
          state_r <= ST_DATA;
        end
        ST_READ:
        begin
          bitCnt_r <= bitCnt_r + 3'h1;
          txShift_r <= {txShift_r[6:0], 1'b0};
          if (byteDone)
            state_r <= ST_READ_ACK;
        end
        ST_READ_ACK:
        begin
          bitCnt_r <= 3'h0;
          txShift_r <= {2'b00, rdHold_r};
          state_r <= sdaIn ? ST_IDLE : ST_READ;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // command word for the register side, held until the next toggle
  always_ff @(posedge scl)
  begin
    if (!sclRstn)
    begin
      cmdTgl_r <= 1'b0;
      cmdOp_r <= 4'h0;
      cmdCh_r <= 1'b0;
      cmdIdx_r <= 2'h0;
      cmdData_r <= 6'h00;
    end
    else if (issueInstr)
    begin
      cmdTgl_r <= ~cmdTgl_r;
      cmdOp_r <= rxByte[7:INS_OP_LSB];
      cmdCh_r <= rxByte[INS_CH_BIT];
      cmdIdx_r <= rxByte[INS_IDX_LSB+1:INS_IDX_LSB];
    end
    else if (issueData)
    begin
      cmdTgl_r <= ~cmdTgl_r;
      cmdOp_r <= instr_r[7:INS_OP_LSB];
      cmdCh_r <= instr_r[INS_CH_BIT];
      cmdIdx_r <= instr_r[INS_IDX_LSB+1:INS_IDX_LSB];
      cmdData_r <= rxByte[CODE_W-1:0];
    end
  end

  // read data taken over once the register side has answered
  always_ff @(posedge scl)
  begin
    if (!sclRstn)
    begin
      ackSeen_r <= 1'b0;
      rdHold_r <= 6'h00;
    end
    else
    begin
      ackSeen_r <= ackSync;
      if (ackSync != ackSeen_r)
        rdHold_r <= readback_r;
    end
  end

  // open-drain drive changes only while scl is low
  always_ff @(negedge scl)
  begin
    if (!sclRstn)
      sdaOe_r <= 1'b0;
    else if ((state_r == ST_ADDR_ACK) || (state_r == ST_INSTR_ACK) || (state_r == ST_DATA_ACK))
      sdaOe_r <= 1'b1;
    else if (state_r == ST_READ)
      sdaOe_r <= ~txShift_r[7];
    else
      sdaOe_r <= 1'b0;
  end

  assign sdaOe = sdaOe_r;
  assign sdaOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // reference clock domain
  dwr_sync #(.WIDTH(1)) uCmdSync (
    .clk(ref_clk),
    .rstn(rstn),
    .d(cmdTgl_r),
    .q(cmdSync)
  );
  assign cmdEdge = cmdSync ^ cmdSeen_r;

  // command edge and power-up recall request
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cmdSeen_r <= 1'b0;
      recallPend_r <= 1'b1;
    end
    else
    begin
      cmdSeen_r <= cmdSync;
      recallPend_r <= 1'b0;
    end
  end

  // next wiper codes
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      wiperSetting_nxt[c] = wiperSetting_r[c];
      if (recallPend_r)
        wiperSetting_nxt[c] = storedWiperSetting_r[c][0];
      else if (cmdEdge && (cmdCh_r == c[0]))
      begin
        if (cmdOp_r == OP_WR_WIPER)
          wiperSetting_nxt[c] = cmdData_r;
        else if (cmdOp_r == OP_RECALL)
          wiperSetting_nxt[c] = storedWiperSetting_r[c][cmdIdx_r];
        else if ((cmdOp_r == OP_INCDEC) && cmdData_r[INC_BIT] && (wiperSetting_r[c] != CODE_MAX))
          wiperSetting_nxt[c] = wiperSetting_r[c] + 6'h01;
        else if ((cmdOp_r == OP_INCDEC) && !cmdData_r[INC_BIT] && (wiperSetting_r[c] != 6'h00))
          wiperSetting_nxt[c] = wiperSetting_r[c] - 6'h01;
      end
    end
  end

  // wiper codes and one-hot taps, low end at bit 0
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      wiperSetting_r <= '{default: 6'h00};
      wiperOutCh0 <= TAP_ONE;
      wiperOutCh1 <= TAP_ONE;
    end
    else
    begin
      wiperSetting_r <= wiperSetting_nxt;
      wiperOutCh0 <= TAP_ONE << wiperSetting_nxt[0];
      wiperOutCh1 <= TAP_ONE << wiperSetting_nxt[1];
    end
  end

  // stored settings, four per channel
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      storedWiperSetting_r <= '{default: '{default: STORED_RESET}};
    else if (cmdEdge && (cmdOp_r == OP_WR_STORED))
      storedWiperSetting_r[cmdCh_r][cmdIdx_r] <= cmdData_r;
    else if (cmdEdge && (cmdOp_r == OP_SAVE))
      storedWiperSetting_r[cmdCh_r][cmdIdx_r] <= wiperSetting_r[cmdCh_r];
  end

  // read answers, toggled back to the serial side
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      readback_r <= 6'h00;
      rdTgl_r <= 1'b0;
    end
    else if (cmdEdge && (cmdOp_r == OP_RD_WIPER))
    begin
      readback_r <= wiperSetting_r[cmdCh_r];
      rdTgl_r <= ~rdTgl_r;
    end
    else if (cmdEdge && (cmdOp_r == OP_RD_STORED))
    begin
      readback_r <= storedWiperSetting_r[cmdCh_r][cmdIdx_r];
      rdTgl_r <= ~rdTgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_recall;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(rstn) |=> (wiperSetting_r[0] == storedWiperSetting_r[0][0])
                    && (wiperSetting_r[1] == storedWiperSetting_r[1][0]);
  endproperty
  a_recall: assert property (p_recall) else $error("wiper not recalled");

  property p_onehot;
    @(posedge ref_clk) disable iff (!rstn)
    $onehot(wiperOutCh0) && $onehot(wiperOutCh1);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap select not one-hot");

  property p_tapmap;
    @(posedge ref_clk) disable iff (!rstn)
    wiperOutCh0[wiperSetting_r[0]] && wiperOutCh1[wiperSetting_r[1]];
  endproperty
  a_tapmap: assert property (p_tapmap) else $error("tap does not match code");

  property p_write;
    @(posedge ref_clk) disable iff (!rstn)
    (cmdEdge && !recallPend_r && (cmdOp_r == OP_WR_WIPER))
      |=> (wiperSetting_r[cmdCh_r] == cmdData_r) && $stable(wiperSetting_r[~cmdCh_r]);
  endproperty
  a_write: assert property (p_write) else $error("wiper write lost");

  property p_store;
    @(posedge ref_clk) disable iff (!rstn)
    (cmdEdge && (cmdOp_r == OP_WR_STORED))
      |=> (storedWiperSetting_r[cmdCh_r][cmdIdx_r] == cmdData_r);
  endproperty
  a_store: assert property (p_store) else $error("stored write lost");

  property p_save;
    @(posedge ref_clk) disable iff (!rstn)
    (cmdEdge && (cmdOp_r == OP_SAVE))
      |=> (storedWiperSetting_r[cmdCh_r][cmdIdx_r] == $past(wiperSetting_r[cmdCh_r]));
  endproperty
  a_save: assert property (p_save) else $error("save did not copy wiper");

  property p_inc;
    @(posedge ref_clk) disable iff (!rstn)
    (cmdEdge && !recallPend_r && (cmdOp_r == OP_INCDEC) && cmdData_r[INC_BIT]
      && (wiperSetting_r[cmdCh_r] != CODE_MAX))
      |=> (wiperSetting_r[cmdCh_r] == $past(wiperSetting_r[cmdCh_r]) + 6'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_nomatch;
    @(posedge scl) disable iff (!sclRstn)
    ((state_r == ST_ADDR) && byteDone && !startFlag_r && !addrHit) |=> !sdaOe [*2];
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("answered foreign address");

  property p_ack;
    @(posedge scl) disable iff (!sclRstn)
    ((state_r == ST_ADDR) && byteDone && !startFlag_r && addrHit) |=> sdaOe;
  endproperty
  a_ack: assert property (p_ack) else $error("address not acknowledged");

  property p_rdbit;
    @(posedge scl) disable iff (!sclRstn)
    ((state_r == ST_READ) && $past(state_r == ST_READ)) |-> (sdaOe == ~txShift_r[7]);
  endproperty
  a_rdbit: assert property (p_rdbit) else $error("read bit mismatch");

  c_write: cover property (@(posedge ref_clk) disable iff (!rstn)
    cmdEdge && (cmdOp_r == OP_WR_WIPER));
  c_read: cover property (@(posedge scl) disable iff (!sclRstn) state_r == ST_READ_ACK);
  c_incdec: cover property (@(posedge ref_clk) disable iff (!rstn)
    cmdEdge && (cmdOp_r == OP_INCDEC));
  c_recall: cover property (@(posedge ref_clk) disable iff (!rstn)
    cmdEdge && (cmdOp_r == OP_RECALL));
endmodule

// file: testbench/dwr_bus_master.sv
// behavioural two-wire bus master driving scl and pulling sda low
// assumes an outside pull-up resolves sda from all open-drain pullers
module dwr_bus_master (
  // serial bus
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 15;

  ////////////////////////////////////////////////////////////////////////////
  // idle bus: clock high and data released
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // clocks with sda released, to flush the link-side reset or pass new strap values
  task automatic clocks(input int n);
    repeat (n)
    begin
      scl = 1'b0;
      #HALF;
      scl = 1'b1;
      #HALF;
    end
  endtask

  // start or repeated start; long low first covers the read answer latency
  task automatic start();
    scl = 1'b0;
    sdaLow = 1'b0;
    #300;
    scl = 1'b1;
    #7;
    sdaLow = 1'b1;
    #8;
    scl = 1'b0;
  endtask

  // one bit: data changes only while scl is low
  task automatic sendBit(input logic b);
    #2;
    sdaLow = ~b;
    #(HALF - 2);
    scl = 1'b1;
    #HALF;
    scl = 1'b0;
  endtask

  // one bit from the wire, sampled at the rising edge
  task automatic getBit(output logic b);
    #2;
    sdaLow = 1'b0;
    #(HALF - 2);
    scl = 1'b1;
    b = sda;
    #HALF;
    scl = 1'b0;
  endtask

  // byte out, msb first, then the slave's acknowledge
  task automatic txByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      sendBit(d[i]);
    getBit(b);
    ack = ~b;
  endtask

  // byte in, then acknowledge to continue or release to end
  task automatic rxByte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      getBit(d[i]);
    sendBit(~more);
  endtask

  // stop, leaving scl high and standing still
  task automatic stop();
    #2;
    sdaLow = 1'b1;
    #(HALF - 2);
    scl = 1'b1;
    #7;
    sdaLow = 1'b0;
  endtask
endmodule

// file: testbench/tb_dual_wiper_register_i2c.sv
// self-checking bench for the dual wiper register block
// assumes the bus master model in its own file and a pull-up on sda
module tb_dual_wiper_register_i2c
  import dwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic refClk;
  logic rstn;
  logic [3:0] pins;
  logic scl;
  logic sda;
  logic sdaLow;
  logic sdaOut;
  logic sdaOe;
  logic [63:0] wiperCh0;
  logic [63:0] wiperCh1;
  int num_errors = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////
  // wired-and data line with pull-up
  assign sda = ~(sdaLow | (sdaOe & ~sdaOut));

  dwr_wiper_regs DUT (
    .ref_clk(refClk), .rstn(rstn), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addrPinBit0(pins[0]), .addrPinBit1(pins[1]),
    .addrPinBit2(pins[2]), .addrPinBit3(pins[3]),
    .wiperOutCh0(wiperCh0), .wiperOutCh1(wiperCh1)
  );

  dwr_bus_master mst (.scl(scl), .sdaLow(sdaLow), .sda(sda));

  // reference clock
  initial
  begin
    refClk = 1'b0;
    forever #25 refClk = ~refClk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // compare and report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      num_errors++;
    end
  endtask

  function automatic logic [7:0] adr(input logic [3:0] p, input logic rd);
    return {DEV_TYPE, p, rd};
  endfunction

  function automatic logic [7:0] ins(input logic [3:0] op, input logic ch,
                                      input logic [1:0] idx);
    return {op, 1'b0, ch, idx};
  endfunction

  // write frame: address, instruction, one data byte; acks compared as a pattern
  task automatic wr(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d,
                    input logic [2:0] expAck);
    logic [2:0] k;
    mst.start();
    mst.txByte(a, k[2]);
    mst.txByte(i, k[1]);
    mst.txByte(d, k[0]);
    mst.stop();
    chk(k, expAck, "ack pattern");
    repeat (5) @(posedge refClk);
    #1;
  endtask

  // read frame with repeated start, one byte then release
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    logic [2:0] k;
    logic [7:0] d;
    mst.start();
    mst.txByte(adr(pins, 1'b0), k[2]);
    mst.txByte(i, k[1]);
    mst.start();
    mst.txByte(adr(pins, 1'b1), k[0]);
    mst.rxByte(1'b0, d);
    mst.stop();
    chk({k, d}, {3'b111, exp}, "read frame");
  endtask

  // one-hot tap select, polled for a bounded number of cycles
  task automatic tap(input logic ch, input logic [5:0] code);
    logic [63:0] exp;
    logic [63:0] got;
    int n;
    exp = TAP_ONE << code;
    n = 0;
    got = ch ? wiperCh1 : wiperCh0;
    while (got !== exp && n < 20)
    begin
      @(posedge refClk);
      #1;
      got = ch ? wiperCh1 : wiperCh0;
      n++;
    end
    chk(got, exp, "tap select");
    if (got !== exp)
      results();
  endtask

  // reset for six cycles; scl runs meanwhile so the link side sees the reset too
  task automatic doReset();
    @(posedge refClk);
    #1;
    rstn = 1'b0;
    fork
      repeat (6) @(posedge refClk);
      mst.clocks(3);
    join
    #1;
    rstn = 1'b1;
    mst.clocks(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (40000) @(posedge refClk);
    num_errors++;
    results();
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    pins = 4'b0011;
    doReset();
    tap(1'b0, 6'h00);
    tap(1'b1, 6'h00);
    chk(sdaOut, 1'b0, "data line never driven high");
    wr(adr(pins, 1'b0), ins(OP_WR_WIPER, 1'b1, 2'h0), 8'h15, 3'b111);
    tap(1'b1, 6'h15);
    tap(1'b0, 6'h00);
    wr(adr(pins, 1'b0), ins(OP_WR_WIPER, 1'b0, 2'h0), 8'hFF, 3'b111);
    tap(1'b0, 6'h3F);
    rd(ins(OP_RD_WIPER, 1'b1, 2'h0), 8'h15);
    rd(ins(OP_RD_WIPER, 1'b0, 2'h0), 8'h3F);
    // every stored setting of both channels gets its own value
    for (int i = 0; i < 8; i++)
      wr(adr(pins, 1'b0), ins(OP_WR_STORED, i[2], i[1:0]), 8'h20 + 8'(i), 3'b111);
    for (int i = 0; i < 8; i++)
      rd(ins(OP_RD_STORED, i[2], i[1:0]), 8'h20 + 8'(i));
    wr(adr(pins, 1'b0), ins(OP_RECALL, 1'b0, 2'h2), 8'h00, 3'b111);
    tap(1'b0, 6'h22);
    tap(1'b1, 6'h15);
    wr(adr(pins, 1'b0), ins(OP_SAVE, 1'b1, 2'h3), 8'h00, 3'b111);
    rd(ins(OP_RD_STORED, 1'b1, 2'h3), 8'h15);
    // stepping with saturation at both ends
    wr(adr(pins, 1'b0), ins(OP_WR_WIPER, 1'b0, 2'h0), 8'h3E, 3'b111);
    wr(adr(pins, 1'b0), ins(OP_INCDEC, 1'b0, 2'h0), 8'h01, 3'b111);
    tap(1'b0, 6'h3F);
    wr(adr(pins, 1'b0), ins(OP_INCDEC, 1'b0, 2'h0), 8'h01, 3'b111);
    tap(1'b0, 6'h3F);
    wr(adr(pins, 1'b0), ins(OP_INCDEC, 1'b0, 2'h0), 8'h00, 3'b111);
    tap(1'b0, 6'h3E);
    wr(adr(pins, 1'b0), ins(OP_WR_WIPER, 1'b1, 2'h0), 8'h00, 3'b111);
    wr(adr(pins, 1'b0), ins(OP_INCDEC, 1'b1, 2'h0), 8'h00, 3'b111);
    tap(1'b1, 6'h00);
    wr(adr(pins, 1'b0), ins(OP_INCDEC, 1'b1, 2'h0), 8'h01, 3'b111);
    tap(1'b1, 6'h01);
    // refusals leave the channel 0 wiper alone
    wr(adr(pins, 1'b0), ins(4'hF, 1'b0, 2'h0), 8'h05, 3'b100);
    wr(adr(4'b1100, 1'b0), ins(OP_WR_WIPER, 1'b0, 2'h0), 8'h05, 3'b000);
    tap(1'b0, 6'h3E);
    // new strap value takes effect
    @(posedge refClk);
    #1;
    pins = 4'b1000;
    mst.clocks(3);
    wr(adr(4'b0011, 1'b0), ins(OP_WR_WIPER, 1'b0, 2'h0), 8'h07, 3'b000);
    wr(adr(4'b1000, 1'b0), ins(OP_WR_WIPER, 1'b0, 2'h0), 8'h05, 3'b111);
    tap(1'b0, 6'h05);
    // second power-up recalls stored setting zero
    doReset();
    tap(1'b0, 6'h00);
    tap(1'b1, 6'h00);
    results();
  end
endmodule
